// ==== acc_correct.sv ====
// Combinational correction arithmetic: offset, gain, PGA and unipolar clamp
`timescale 1ns/1ps
`default_nettype none
module acc_correct #(
   parameter int W = 24
) (
   input  wire logic signed [W-1:0] raw_i,
   input  wire acc_pkg::acc_cal_type cal_i,
   output logic signed [W-1:0]      result_o,
   output logic                     clamped_o
);
   import acc_pkg::*;

   // Elaboration-time refusal of widths the arithmetic cannot serve
   if (W != DATA_W) begin : g_width_check
      $error("acc_correct: width must be 24");
   end

   logic signed [W:0]      diff;
   logic signed [2*W+1:0]  prod;
   logic signed [2*W+5:0]  scaled;
   logic signed [2*W+5:0]  shifted;
   logic signed [W-1:0]    max_pos;
   logic signed [W-1:0]    max_neg;

   always_comb begin
      max_pos   = {1'b0, {(W-1){1'b1}}};
      max_neg   = {1'b1, {(W-1){1'b0}}};
      // Offset is signed; extra bit keeps the difference exact
      diff      = $signed({raw_i[W-1], raw_i}) - $signed({cal_i.offset[W-1], cal_i.offset});
      // Gain is unsigned 1.23, so zero-extend before the signed multiply
      prod      = diff * $signed({1'b0, cal_i.gain});
      scaled    = (2*W+6)'(prod) <<< cal_i.pga;
      if (cal_i.unipolar) begin
         scaled = scaled <<< 1;
      end
      shifted   = scaled >>> GAIN_FRAC_W;
      clamped_o = 1'b0;
      // Saturate rather than wrap; a PGA gain of 8 can overflow 24 bits
      if (cal_i.unipolar && shifted < 0) begin
         result_o  = '0;
         clamped_o = 1'b1;
      end else if (shifted > (2*W+6)'(max_pos)) begin
         result_o  = max_pos;
         clamped_o = 1'b1;
      end else if (shifted < (2*W+6)'(max_neg)) begin
         result_o  = max_neg;
         clamped_o = 1'b1;
      end else begin
         result_o  = shifted[W-1:0];
      end
   end

endmodule : acc_correct
`default_nettype wire

// ==== acc_pkg.sv ====
// Package with constants and carrier types for the calibration correction stage
package acc_pkg;

   // =====================================================================
   // Widths and reset values
   localparam int          DATA_W          = 24;
   localparam int          GAIN_FRAC_W     = 23;
   localparam logic [23:0] OFFSET_RST      = 24'h000000;
   localparam logic [23:0] GAIN_RST        = 24'h800000;
   localparam logic [1:0]  PGA_RST         = 2'h0;
   localparam logic        UNIPOLAR_RST    = 1'b0;

   // =====================================================================
   // Register map (word offsets are byte addresses)
   localparam logic [7:0]  REG_OFFSET_ADDR = 8'h00;
   localparam logic [7:0]  REG_GAIN_ADDR   = 8'h04;
   localparam logic [7:0]  REG_MODE_ADDR   = 8'h08;
   localparam logic [7:0]  REG_DATA_ADDR   = 8'h0c;
   localparam logic [7:0]  REG_STATUS_ADDR = 8'h10;

   // Mode register fields
   localparam int          MODE_PGA_LSB    = 0;
   localparam int          MODE_UNI_BIT    = 2;
   // Status register fields
   localparam int          STAT_READY_BIT  = 0;
   localparam int          STAT_CLAMP_BIT  = 1;

   // =====================================================================
   // Carrier types
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } acc_wb_req_type;

   typedef struct packed {
      logic [23:0] offset;
      logic [23:0] gain;
      logic [1:0]  pga;
      logic        unipolar;
   } acc_cal_type;

endpackage : acc_pkg

// ==== acc_top.sv ====
// Calibration correction stage with Wishbone register slave
// =====================================================================
// Notes on behaviour
// - Offset word signed, resets to zero
// - Gain word unsigned, one integer bit
// - Gain word resets to exact unity
// - Calibration writes leave data register alone
// - Mode changes apply at next conversion
// - Result is (raw-offset) times gain, PGA
// - Unipolar clamps negatives, doubles result
// - Twenty-four bit signed path and words
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module acc_top #(
   parameter int W = acc_pkg::DATA_W
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  ce_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [7:0]            wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   input  wire logic                  raw_valid_i,
   input  wire logic [W-1:0]          raw_data_i,
   output logic      [W-1:0]          data_o,
   output logic                       data_valid_o
);
   import acc_pkg::*;

   // Elaboration-time refusal of widths the register map cannot serve
   if (W != DATA_W) begin : g_width_check
      $error("acc_top: only a 24-bit path is supported");
   end

   // =====================================================================
   // State
   typedef struct packed {
      acc_cal_type  cal;
      logic [W-1:0] data;
      logic         ready;
      logic         clamped;
      logic         dvalid;
      logic         ack;
      logic [31:0]  rdat;
   } acc_state_type;

   acc_state_type   st_r;
   acc_state_type   st_nxt;
   acc_wb_req_type  req;
   logic [W-1:0]    corr;
   logic            corr_clamp;

   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                  adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

   // =====================================================================
   // Arithmetic works on the live settings; captured only on raw_valid_i
   acc_correct #(
      .W (W)
   ) u_correct (
      .raw_i     (raw_data_i),
      .cal_i     (st_r.cal),
      .result_o  (corr),
      .clamped_o (corr_clamp)
   );

   // Byte-lane merge for a 24-bit word
   function automatic logic [23:0] lane_merge(input logic [23:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  sel);
      logic [23:0] v;
      v = old;
      if (sel[0]) begin
         v[7:0] = wd[7:0];
      end
      if (sel[1]) begin
         v[15:8] = wd[15:8];
      end
      if (sel[2]) begin
         v[23:16] = wd[23:16];
      end
      return v;
   endfunction : lane_merge

   // =====================================================================
   // Next state
   always_comb begin
      logic access;
      logic rd_data;
      access        = 1'b0;
      rd_data       = 1'b0;
      st_nxt        = st_r;
      st_nxt.dvalid = 1'b0;
      st_nxt.ack    = 1'b0;

      // One-cycle ack; ack drops the cycle after it is given
      access = req.cyc && req.stb && !st_r.ack;
      if (access) begin
         st_nxt.ack  = 1'b1;
         st_nxt.rdat = '0;
         if (req.we) begin
            case (req.adr)
               REG_OFFSET_ADDR: begin
                  st_nxt.cal.offset = lane_merge(st_r.cal.offset, req.dat, req.sel);
               end
               REG_GAIN_ADDR: begin
                  st_nxt.cal.gain = lane_merge(st_r.cal.gain, req.dat, req.sel);
               end
               REG_MODE_ADDR: begin
                  if (req.sel[0]) begin
                     st_nxt.cal.pga      = req.dat[MODE_PGA_LSB +: 2];
                     st_nxt.cal.unipolar = req.dat[MODE_UNI_BIT];
                  end
               end
               default: begin
               end
            endcase
         end else begin
            case (req.adr)
               REG_OFFSET_ADDR: begin
                  st_nxt.rdat = {8'h00, st_r.cal.offset};
               end
               REG_GAIN_ADDR: begin
                  st_nxt.rdat = {8'h00, st_r.cal.gain};
               end
               REG_MODE_ADDR: begin
                  st_nxt.rdat[MODE_PGA_LSB +: 2] = st_r.cal.pga;
                  st_nxt.rdat[MODE_UNI_BIT]      = st_r.cal.unipolar;
               end
               REG_DATA_ADDR: begin
                  st_nxt.rdat = {{(32-W){1'b0}}, st_r.data};
                  rd_data     = 1'b1;
               end
               REG_STATUS_ADDR: begin
                  st_nxt.rdat[STAT_READY_BIT] = st_r.ready;
                  st_nxt.rdat[STAT_CLAMP_BIT] = st_r.clamped;
               end
               default: begin
                  st_nxt.rdat = '0;
               end
            endcase
         end
      end

      // Reading data clears ready
      if (rd_data) begin
         st_nxt.ready = 1'b0;
      end

      // Completed conversion; set wins over the read clear
      if (raw_valid_i) begin
         st_nxt.data    = corr;
         st_nxt.clamped = corr_clamp;
         st_nxt.ready   = 1'b1;
         st_nxt.dvalid  = 1'b1;
      end
   end

   // =====================================================================
   // Registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r              <= '0;
         st_r.cal.offset   <= OFFSET_RST;
         st_r.cal.gain     <= GAIN_RST;
         st_r.cal.pga      <= PGA_RST;
         st_r.cal.unipolar <= UNIPOLAR_RST;
      end else if (ce_i) begin
         st_r <= st_nxt;
      end
   end

   assign wb_dat_o     = st_r.rdat;
   assign wb_ack_o     = st_r.ack;
   assign data_o       = st_r.data;
   assign data_valid_o = st_r.dvalid;

endmodule : acc_top
`default_nettype wire

// ==== acc_top_asserts.sv ====
// Concurrent checks on the ports of the calibration correction stage
`timescale 1ns/1ps
`default_nettype none
module acc_top_asserts
   import acc_pkg::*;
#(
   parameter int W = DATA_W
) (
   input wire logic          clk_i,
   input wire logic          rst_i,
   input wire logic          ce_i,
   input wire logic          wb_cyc_i,
   input wire logic          wb_stb_i,
   input wire logic          wb_we_i,
   input wire logic [7:0]    wb_adr_i,
   input wire logic [3:0]    wb_sel_i,
   input wire logic [31:0]   wb_dat_i,
   input wire logic [31:0]   wb_dat_o,
   input wire logic          wb_ack_o,
   input wire logic          raw_valid_i,
   input wire logic [W-1:0]  raw_data_i,
   input wire logic [W-1:0]  data_o,
   input wire logic          data_valid_o
);
   // =====================================================================
   // Shadow of settings; any write spoils the reset-value checks
   logic take, conv, cw_r, uni_r;
   assign take = wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o;
   assign conv = raw_valid_i && ce_i;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cw_r  <= 1'b0;
         uni_r <= 1'b0;
      end else if (take && wb_we_i) begin
         cw_r <= 1'b1;
         if (wb_adr_i == REG_MODE_ADDR && wb_sel_i[0]) begin
            uni_r <= wb_dat_i[MODE_UNI_BIT];
         end
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // =====================================================================
   chk_conv_answer: assert property (conv |=> data_valid_o)
      else $error("no result pulse after conversion");
   chk_data_hold: assert property (!conv |=> $stable(data_o) && !data_valid_o)
      else $error("data changed without conversion");
   chk_offset_reset: assert property (take && !wb_we_i && wb_adr_i == REG_OFFSET_ADDR
      && !cw_r |=> wb_dat_o == 32'h0)
      else $error("offset word not zero after reset");
   chk_gain_reset: assert property (take && !wb_we_i && wb_adr_i == REG_GAIN_ADDR
      && !cw_r |=> wb_dat_o == {8'h00, GAIN_RST})
      else $error("gain word not unity after reset");
   chk_ack_answer: assert property (take |=> wb_ack_o)
      else $error("bus access not answered");
   chk_top_zero: assert property (wb_ack_o |-> wb_dat_o[31:24] == 8'h00)
      else $error("read data above bit 23");
   chk_unity_pass: assert property (conv && !cw_r |=> data_o == $past(raw_data_i))
      else $error("uncalibrated result differs from raw");
   chk_uni_clamp: assert property (conv && uni_r |=> !data_o[W-1])
      else $error("negative result in unipolar mode");
endmodule : acc_top_asserts
bind acc_top acc_top_asserts #(.W(W)) i_chk (.*);
`default_nettype wire

// ==== test_adc_calibration_correction.sv ====
// Self-checking bench for the calibration correction stage
`timescale 1ns/1ps
`default_nettype none
module test_adc_calibration_correction;
   import acc_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, rv = 1'b0, ack, dv;
   acc_wb_req_type wb = '0;
   logic [23:0] raw = '0, dout;
   logic [31:0] dat_o, got, rd, exp_q[$];
   int          fails = 0, samples_checked = 0, cyc = 0, seed = 32'h24e5;
   acc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb.cyc),
      .wb_stb_i(wb.stb), .wb_we_i(wb.we), .wb_adr_i(wb.adr), .wb_sel_i(wb.sel),
      .wb_dat_i(wb.dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .raw_valid_i(rv),
      .raw_data_i(raw), .data_o(dout), .data_valid_o(dv));
   always #4 clk_i = ~clk_i;
   // =====================================================================
   // Reference arithmetic; 64 bits so no step wraps before saturation
   function automatic logic [23:0] model(logic [23:0] r, acc_cal_type c);
      longint p;
      p = (longint'($signed(r)) - longint'($signed(c.offset))) * longint'(c.gain);
      p = (p <<< (int'(c.pga) + int'(c.unipolar))) >>> 23;
      if (c.unipolar && p < 0) p = 0;
      if (p > 64'sh7fffff) p = 64'sh7fffff;
      if (p < -64'sh800000) p = -64'sh800000;
      return p[23:0];
   endfunction : model
   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d);
      @(posedge clk_i);
      wb <= '{1'b1, 1'b1, we, adr, 4'hf, d};
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      wb <= '0;
   endtask : bus
   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, adr, 32'h0);
   endtask : rd_chk
   task automatic conv(input logic [23:0] r, input acc_cal_type c, output logic [23:0] e);
      @(posedge clk_i);
      rv  <= 1'b1;
      raw <= r;
      e = model(r, c);
      exp_q.push_back({8'h00, e});
   endtask : conv
   task automatic report_and_stop;
      if (fails == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop
   // =====================================================================
   // Result watcher and hang guard
   always @(posedge clk_i) begin
      cyc++;
      if (dv === 1'b1 || (ack === 1'b1 && wb.we === 1'b0)) begin
         got = (dv === 1'b1) ? {8'h00, dout} : dat_o;
         rd = exp_q.pop_front();
         samples_checked++;
         if (got !== rd) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, rd);
         end
      end
      if (cyc > 3000) begin
         fails++;
         report_and_stop();
      end
   end
   initial begin
      acc_cal_type c;
      logic [23:0] last;
      c = '{OFFSET_RST, GAIN_RST, PGA_RST, UNIPOLAR_RST};
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(REG_OFFSET_ADDR, 32'h0);
      rd_chk(REG_GAIN_ADDR, {8'h00, GAIN_RST});
      rd_chk(8'h20, 32'h0);
      rd = $random(seed);
      conv(rd[23:0], c, last);
      conv(~rd[23:0], c, last);
      // Mode index walks every pga and polarity; gain ends at both limits
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i);
         rv <= 1'b0;
         rd = $random(seed);
         c.offset = {{3{rd[20]}}, rd[20:0]};
         c.gain = (i == 0) ? 24'h0 : (i == 7) ? 24'hffffff : rd[31:8];
         c.pga = i[1:0];
         c.unipolar = i[2];
         bus(1'b1, REG_OFFSET_ADDR, {8'h00, c.offset});
         bus(1'b1, REG_GAIN_ADDR, {8'h00, c.gain});
         bus(1'b1, REG_MODE_ADDR, {29'h0, c.unipolar, c.pga});
         rd_chk(REG_GAIN_ADDR, {8'h00, c.gain});
         rd_chk(REG_DATA_ADDR, {8'h00, last});
         rd = $random(seed);
         conv({{3{rd[20]}}, rd[20:0]}, c, last);
      end
      // Frozen enable must swallow a pending conversion; one result only
      @(posedge clk_i);
      rv <= 1'b0;
      @(posedge clk_i);
      ce_i <= 1'b0;
      rv   <= 1'b1;
      repeat (2) @(posedge clk_i);
      conv(24'h123456, c, last);
      ce_i <= 1'b1;
      @(posedge clk_i);
      rv <= 1'b0;
      repeat (3) @(posedge clk_i);
      report_and_stop();
   end
endmodule : test_adc_calibration_correction
`default_nettype wire
